// >>> kwu_pkg.sv
// Package for the keyboard wake unit: register map, fields, reset values
package kwu_pkg;
  localparam int KWU_PIN_COUNT = 5;
  localparam int KWU_ADDR_W = 4;
  localparam int KWU_DATA_W = 32;
  // Byte addresses of the word registers
  localparam logic [3:0] KWU_OFS_STATUS_CTRL = 4'h0;
  localparam logic [3:0] KWU_OFS_PIN_ENABLE = 4'h4;
  localparam logic [3:0] KWU_OFS_SYS_CTRL = 4'h8;
  // Status/control fields
  localparam int KWU_BIT_PENDING = 3;
  localparam int KWU_BIT_ACK = 2;
  localparam int KWU_BIT_MASK = 1;
  localparam int KWU_BIT_SENS = 0;
  // System control fields
  localparam int KWU_BIT_BREAK_CLR_EN = 0;
  localparam int KWU_BIT_BREAK_STATE = 1;
  localparam int KWU_BIT_CPU_ASLEEP = 2;
  // Reset values
  localparam logic KWU_RST_MASK = 1'b0;
  localparam logic KWU_RST_SENS = 1'b0;
  localparam logic [4:0] KWU_RST_PIN_ENABLE = 5'h00;
  localparam logic KWU_RST_BREAK_CLR_EN = 1'b0;
  localparam logic [15:0] KWU_VECTOR_ADDR_HI = 16'hFFD2;
  localparam logic [15:0] KWU_VECTOR_ADDR_LO = 16'hFFD3;
  localparam logic [31:0] KWU_UNMAPPED_DATA = 32'h0000_0000;
  typedef enum logic [1:0] {
    KWU_BUS_IDLE,
    KWU_BUS_ANSWER
  } kwu_bus_state_e;
endpackage

// >>> kwu_key_wake_unit.sv
// Keyboard wake unit: five pin keyboard interrupt with Avalon-MM registers
// Function
// - Five enabled key pins, port G bits 0-2 and H 0-1, one request
// - Enable bit switches on that pin's pull-up
// - Request latched when enabled pins fall after all were high
// - Edge mode: no new request while another enabled pin is low
// - Level mode: request holds until acknowledged and all pins high
// - Edge mode: acknowledge clears the request at once
// - Vector fetch acts as acknowledge
// - Unmasked request vectors through the two fixed vector locations
// - Falling edge after acknowledge write latches a fresh request
// - Acknowledge bit is write-one-to-clear, reads zero
// - Reset clears request and sensitivity select
// - Pending flag shows request regardless of mask
// - Mask bit blocks the request from the CPU
// - Sensitivity select: 1 edge and level, 0 edge only
// - Status register bits 7-4 read as zero
// - Enable bits choose pin sources, cleared by reset
// - Enable forces pin to input, reads still need direction zero
// - Unmasked request wakes the CPU from wait
// - Unmasked request brings the CPU out of stop
// - In break with clear enable zero, acknowledge writes ignored
`timescale 1ns/1ns
module kwu_key_wake_unit
  import kwu_pkg::*;
#(
  parameter int PIN_COUNT = kwu_pkg::KWU_PIN_COUNT
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [kwu_pkg::KWU_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [kwu_pkg::KWU_DATA_W-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [kwu_pkg::KWU_DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Key pins
  input wire logic [PIN_COUNT-1:0] key_input_pin_i,
  input wire logic [PIN_COUNT-1:0] port_dir_i,
  output logic [PIN_COUNT-1:0] pin_pullup_en_o,
  output logic [PIN_COUNT-1:0] pin_dir_o,
  output logic [PIN_COUNT-1:0] pin_read_level_o,
  // CPU side
  input wire logic vector_fetch_i,
  input wire logic [15:0] vector_addr_i,
  input wire logic break_state_i,
  input wire logic cpu_wait_i,
  input wire logic cpu_stop_i,
  output logic cpu_irq_o,
  output logic cpu_wake_o,
  output logic key_pending_flag_o
);
  import kwu_pkg::*;

  logic [PIN_COUNT-1:0] sync1_reg;
  logic [PIN_COUNT-1:0] sync2_reg;
  logic [PIN_COUNT-1:0] pin_source_enables_reg;
  logic key_request_mask_reg;
  logic key_sensitivity_select_reg;
  logic break_clear_enable_reg;
  logic latch_reg;
  logic latch_next;
  logic all_high_reg;
  logic ack_seen_reg;
  kwu_bus_state_e bus_state_reg;
  logic [KWU_DATA_W-1:0] rdata_next;
  logic [PIN_COUNT-1:0] low_now;
  logic any_low;
  logic wr_take;
  logic sc_hit;
  logic ack_write;
  logic vec_ack;
  logic ack_any;
  logic fall_event;

  // Pins come from outside: two flops before any use
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
    end else begin
      sync1_reg <= key_input_pin_i;
      sync2_reg <= sync1_reg;
    end
  end

  // Only enabled pins take part
  assign low_now = ~sync2_reg & pin_source_enables_reg;
  assign any_low = |low_now;

  // Remembers that every enabled pin was high last cycle
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      all_high_reg <= 1'b1;
    end else begin
      all_high_reg <= ~any_low;
    end
  end

  // New request only when a low appears after all were high
  assign fall_event = any_low & all_high_reg;

  // Bus: one wait cycle, answer in the next
  assign wr_take = avs_write_i && bus_state_reg == KWU_BUS_ANSWER;
  assign sc_hit = avs_address_i == KWU_OFS_STATUS_CTRL;
  assign ack_write = wr_take && sc_hit && avs_byteenable_i[0]
    && avs_writedata_i[KWU_BIT_ACK]
    && (!break_state_i || break_clear_enable_reg);

  // Fetch of either vector byte acknowledges
  assign vec_ack = vector_fetch_i && (vector_addr_i == KWU_VECTOR_ADDR_HI
    || vector_addr_i == KWU_VECTOR_ADDR_LO);
  assign ack_any = ack_write | vec_ack;

  // Set wins over acknowledge so a fresh edge is never lost
  always_comb begin
    latch_next = latch_reg;
    if (ack_any && !key_sensitivity_select_reg) begin
      latch_next = 1'b0;
    end
    if (key_sensitivity_select_reg && (ack_any || ack_seen_reg)
        && !any_low) begin
      latch_next = 1'b0;
    end
    if (fall_event) begin
      latch_next = 1'b1;
    end
  end

  // Level mode remembers an early acknowledge until all pins return
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_seen_reg <= 1'b0;
    end else if (fall_event || !latch_reg) begin
      ack_seen_reg <= 1'b0;
    end else if (ack_any && key_sensitivity_select_reg) begin
      ack_seen_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      latch_reg <= 1'b0;
    end else begin
      // Same value the outputs see, so flag and readback agree
      latch_reg <= latch_next;
    end
  end

  // Control registers
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      key_request_mask_reg <= KWU_RST_MASK;
      key_sensitivity_select_reg <= KWU_RST_SENS;
    end else if (wr_take && sc_hit && avs_byteenable_i[0]) begin
      key_request_mask_reg <= avs_writedata_i[KWU_BIT_MASK];
      key_sensitivity_select_reg <= avs_writedata_i[KWU_BIT_SENS];
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_source_enables_reg <= KWU_RST_PIN_ENABLE[PIN_COUNT-1:0];
    end else if (wr_take && avs_address_i == KWU_OFS_PIN_ENABLE
        && avs_byteenable_i[0]) begin
      pin_source_enables_reg <= avs_writedata_i[PIN_COUNT-1:0];
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      break_clear_enable_reg <= KWU_RST_BREAK_CLR_EN;
    end else if (wr_take && avs_address_i == KWU_OFS_SYS_CTRL
        && avs_byteenable_i[0]) begin
      break_clear_enable_reg <= avs_writedata_i[KWU_BIT_BREAK_CLR_EN];
    end
  end

  // Read mux; unmapped reads return zero, writes there are dropped
  always_comb begin
    rdata_next = KWU_UNMAPPED_DATA;
    case (avs_address_i)
      KWU_OFS_STATUS_CTRL: begin
        rdata_next[KWU_BIT_PENDING] = latch_reg;
        rdata_next[KWU_BIT_MASK] = key_request_mask_reg;
        rdata_next[KWU_BIT_SENS] = key_sensitivity_select_reg;
        // Acknowledge and bits 7-4 stay zero
        rdata_next[KWU_BIT_ACK] = 1'b0;
      end
      KWU_OFS_PIN_ENABLE: begin
        rdata_next[PIN_COUNT-1:0] = pin_source_enables_reg;
      end
      KWU_OFS_SYS_CTRL: begin
        rdata_next[KWU_BIT_BREAK_CLR_EN] = break_clear_enable_reg;
        rdata_next[KWU_BIT_BREAK_STATE] = break_state_i;
        rdata_next[KWU_BIT_CPU_ASLEEP] = cpu_wait_i | cpu_stop_i;
      end
      default: begin
        rdata_next = KWU_UNMAPPED_DATA;
      end
    endcase
  end

  // Waitrequest high until the answer cycle
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_state_reg <= KWU_BUS_IDLE;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= KWU_UNMAPPED_DATA;
    end else begin
      case (bus_state_reg)
        KWU_BUS_IDLE: begin
          if (avs_read_i || avs_write_i) begin
            bus_state_reg <= KWU_BUS_ANSWER;
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o <= rdata_next;
          end
        end
        KWU_BUS_ANSWER: begin
          bus_state_reg <= KWU_BUS_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
        default: begin
          bus_state_reg <= KWU_BUS_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
      endcase
    end
  end

  // Pin control, registered
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_pullup_en_o <= '0;
      pin_dir_o <= '0;
      pin_read_level_o <= '0;
    end else begin
      pin_pullup_en_o <= pin_source_enables_reg;
      pin_dir_o <= port_dir_i & ~pin_source_enables_reg;
      // Level visible to software only with direction bit zero
      pin_read_level_o <= sync2_reg & ~port_dir_i;
    end
  end

  // CPU lines, registered
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cpu_irq_o <= 1'b0;
      cpu_wake_o <= 1'b0;
      key_pending_flag_o <= 1'b0;
    end else begin
      cpu_irq_o <= latch_next & ~key_request_mask_reg;
      // Wake works in both wait and stop since logic stays clocked
      cpu_wake_o <= latch_next & ~key_request_mask_reg
        & (cpu_wait_i | cpu_stop_i);
      key_pending_flag_o <= latch_next;
    end
  end
endmodule

// >>> kwu_key_pad.sv
// Key switch model for the five key pins
`timescale 1ns/1ns
module kwu_key_pad (
  input wire logic ref_clk_i,
  input wire logic [4:0] pressed_i,
  input wire logic [4:0] pullup_en_i,
  output logic [4:0] pin_o
);
  // Unpulled pins wander, never a trusted level
  logic [4:0] drift = 5'h15;
  always @(posedge ref_clk_i) drift <= ~drift;
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pin_o[i] = pressed_i[i] ? 1'b0 : (pullup_en_i[i] ? 1'b1 : drift[i]);
    end
  end
endmodule

// >>> kwu_checker_props.sv
// Port checker for the keyboard wake unit
`timescale 1ns/1ns
module kwu_checker_props #(
  parameter int PIN_COUNT = 5
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic [PIN_COUNT-1:0] key_input_pin_i,
  input wire logic [PIN_COUNT-1:0] pin_pullup_en_o,
  input wire logic [PIN_COUNT-1:0] pin_dir_o,
  input wire logic cpu_wait_i,
  input wire logic cpu_stop_i,
  input wire logic cpu_irq_o,
  input wire logic cpu_wake_o,
  input wire logic key_pending_flag_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  AST_IRQ_PEND: assert property (cpu_irq_o |-> key_pending_flag_o)
    else $error("irq without pending");
  AST_WAKE: assert property (cpu_wake_o |->
    $past(cpu_wait_i | cpu_stop_i) || $past(cpu_wait_i | cpu_stop_i, 2))
    else $error("wake while awake");
  AST_ONE_ANSWER: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("answer too long");
  AST_ANSWER: assert property ((avs_read_i || avs_write_i) &&
    avs_waitrequest_o |=> !avs_waitrequest_o) else $error("no answer");
  AST_DIR: assert property ((pin_dir_o & pin_pullup_en_o) == '0)
    else $error("enabled pin not input");
  AST_QUIET: assert property ((&key_input_pin_i) [*6] ##0
    !key_pending_flag_o |=> !key_pending_flag_o) else $error("false latch");
  AST_RISE: assert property ($rose(key_pending_flag_o) |->
    !(&$past(key_input_pin_i, 2)) || !(&$past(key_input_pin_i, 3)) ||
    !(&$past(key_input_pin_i, 4)) || !(&$past(key_input_pin_i, 5)))
    else $error("latch without low pin");
  AST_PULL: assert property (!$past(avs_write_i) &&
    !$past(avs_write_i, 2) |-> $stable(pin_pullup_en_o))
    else $error("pull-up changed unasked");
  cover property ($rose(cpu_irq_o));
  cover property ($rose(cpu_wake_o));
  cover property (avs_read_i && !avs_waitrequest_o);
  cover property ($fell(key_pending_flag_o));
endmodule
bind kwu_key_wake_unit kwu_checker_props #(.PIN_COUNT(PIN_COUNT)) chk (
  .ref_clk_i(ref_clk_i),
  .rst_i(rst_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o),
  .key_input_pin_i(key_input_pin_i),
  .pin_pullup_en_o(pin_pullup_en_o),
  .pin_dir_o(pin_dir_o),
  .cpu_wait_i(cpu_wait_i),
  .cpu_stop_i(cpu_stop_i),
  .cpu_irq_o(cpu_irq_o),
  .cpu_wake_o(cpu_wake_o),
  .key_pending_flag_o(key_pending_flag_o)
);

// >>> kwu_key_wake_unit_test.sv
// Self-checking bench for the keyboard wake unit
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected %0t %h %h", $time, a, b); end end
module kwu_key_wake_unit_test;
  import kwu_pkg::*;
  localparam logic [3:0] SC = KWU_OFS_STATUS_CTRL;
  localparam logic [3:0] EN = KWU_OFS_PIN_ENABLE;
  logic ref_clk_i = 0, rst_i = 1, rd = 0, wr = 0, vf = 0, brk = 0, cw = 0;
  logic cs = 0, wt, irq, wake, pend;
  logic [3:0] adr = 0;
  logic [31:0] wd = 0, q, rdata;
  logic [4:0] key = 0, dir = 0, pin, pu, pdir, lvl;
  logic [15:0] va = 0;
  int fail_count = 0, tests_run = 0;
  always #2 ref_clk_i = ~ref_clk_i;
  kwu_key_pad pad (.ref_clk_i(ref_clk_i), .pressed_i(key), .pullup_en_i(pu),
    .pin_o(pin));
  kwu_key_wake_unit uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(q),
    .avs_waitrequest_o(wt), .key_input_pin_i(pin), .port_dir_i(dir),
    .pin_pullup_en_o(pu), .pin_dir_o(pdir), .pin_read_level_o(lvl),
    .vector_fetch_i(vf), .vector_addr_i(va), .break_state_i(brk),
    .cpu_wait_i(cw), .cpu_stop_i(cs), .cpu_irq_o(irq), .cpu_wake_o(wake),
    .key_pending_flag_o(pend));
  task automatic conclude;
    $display("compares %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  // Extra edge at the end keeps two requests from one time step
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (wt !== 1'b0 && n < 40);
    rdata = q;
    wr <= 0;
    rd <= 0;
    if (wt !== 1'b0) begin
      fail_count++;
      conclude();
    end
    @(posedge ref_clk_i);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    bus(0, a, 0);
    `CHK(rdata, e)
  endtask
  task automatic vfetch(input logic [15:0] a);
    va <= a;
    vf <= 1;
    cyc(1);
    vf <= 0;
    cyc(3);
  endtask
  task automatic t_reset;
    rdc(SC, 32'h0);
    rdc(EN, 32'h0);
    `CHK({irq, pend, wake}, 3'b000)
  endtask
  task automatic t_disabled;
    bus(1, EN, 32'h1);
    cyc(6);
    bus(1, SC, 32'h4);
    `CHK(pu, 5'h01)
    key <= 5'h02;
    cyc(6);
    `CHK(pend, 1'b0)
    rdc(4'hC, 32'h0);
    key <= 0;
  endtask
  task automatic t_setup;
    bus(1, SC, 32'h2);
    bus(1, EN, 32'h1F);
    dir <= 5'h1F;
    cyc(6);
    bus(1, SC, 32'h6);
    rdc(SC, 32'h2);
    bus(1, SC, 32'h0);
    `CHK(pdir, 5'h00)
    dir <= 0;
  endtask
  task automatic t_edge;
    key <= 5'h01;
    cyc(6);
    `CHK({pend, irq}, 2'b11)
    `CHK(lvl, 5'h1E)
    rdc(SC, 32'h8);
    key <= 5'h03;
    bus(1, SC, 32'h4);
    cyc(1);
    `CHK(pend, 1'b0)
    cyc(6);
    `CHK(pend, 1'b0)
    key <= 0;
    cyc(6);
    key <= 5'h04;
    cyc(6);
    `CHK(irq, 1'b1)
    bus(1, SC, 32'h2);
    cyc(2);
    `CHK({pend, irq}, 2'b10)
    vfetch(KWU_VECTOR_ADDR_LO);
    `CHK(pend, 1'b0)
    bus(1, SC, 32'h0);
    key <= 0;
    cyc(6);
  endtask
  task automatic t_wake;
    cw <= 1;
    key <= 5'h10;
    cyc(6);
    `CHK(wake, 1'b1)
    cw <= 0;
    cs <= 1;
    cyc(3);
    `CHK(wake, 1'b1)
    bus(1, SC, 32'h4);
    cs <= 0;
    key <= 0;
    cyc(6);
  endtask
  task automatic t_break;
    brk <= 1;
    key <= 5'h01;
    cyc(6);
    bus(1, SC, 32'h4);
    cyc(2);
    `CHK(pend, 1'b1)
    bus(1, KWU_OFS_SYS_CTRL, 32'h1);
    rdc(KWU_OFS_SYS_CTRL, 32'h3);
    bus(1, SC, 32'h4);
    brk <= 0;
    cyc(2);
    `CHK(pend, 1'b0)
    bus(1, KWU_OFS_SYS_CTRL, 32'h0);
    key <= 0;
    cyc(6);
  endtask
  task automatic t_level;
    bus(1, SC, 32'h1);
    rdc(SC, 32'h1);
    key <= 5'h08;
    cyc(6);
    bus(1, SC, 32'h5);
    vfetch(KWU_VECTOR_ADDR_HI);
    `CHK(pend, 1'b1)
    key <= 0;
    cyc(6);
    `CHK(pend, 1'b0)
    key <= 5'h10;
    cyc(6);
    rst_i <= 1;
    cyc(2);
    rst_i <= 0;
    cyc(2);
    `CHK(pend, 1'b0)
    rdc(SC, 32'h0);
  endtask
  initial begin
    cyc(5);
    rst_i <= 0;
    t_reset();
    t_disabled();
    t_setup();
    t_edge();
    t_wake();
    t_break();
    t_level();
    conclude();
  end
endmodule
